// [hw/tcc_timer16.sv]
// 16-bit timer/counter with capture, two compare channels and its register file.
// Assumes an AHB-Lite master, byte data in hwdata[7:0], and a system that
// supplies the global interrupt enable and vector-taken strobes.
// Behaviour
// - With filter on, filtered capture input changes only after four equal samples.
// - Filtered capture path lags the unfiltered one by four clock cycles.
// - Edge select zero captures on falling edge, one on rising edge.
// - Capture copies counter into capture register and sets the capture flag.
// - Capture input is disconnected while capture register is the counting ceiling.
// - Comparator output may replace the capture pin as capture source.
// - Clock select 000 stops; 001..101 divide I/O clock by 1,8,64,256,1024.
// - Code 110 counts falling, 111 rising edges of the external count pin.
// - External pin edges count even when the pin is driven as output.
// - Force-compare bit forces an immediate match, only in non-PWM modes.
// - Forced match acts per compare-output mode bits present at the strobe.
// - Forced match raises no flag and never clears the counter.
// - Force-compare bits always read as zero.
// - Sixteen-bit registers pass through one shared high-byte latch.
// - Counter write blocks compare matches on the following timer clock.
// - Both compare registers are compared continuously; matches drive flags and outputs.
// - Each source requests its vector when mask, global enable and flag are set.
// - Unused mask and flag bits 7,6,4,3 read as zero.
// - Compare flag sets in the timer clock after counter equals compare value.
// - Flags clear on vector taken or on writing one to them.
// - Four-bit waveform mode joins two bits of control_b and two of control_a.
// - With capture register as ceiling, capture flag sets when counter reaches it.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
module tcc_timer16 (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic capture_pin,
  input wire logic ext_count_pin,
  input wire logic acomp_out,
  input wire logic acomp_capture_sel,
  input wire logic irq_global_en,
  input wire logic [3:0] vector_ack,
  output logic [3:0] irq_req,
  output logic compare_out_a,
  output logic compare_out_b
);
  import tcc_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic tcc_kind_type kind_of(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: kind_of = WAVE_PHASE;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: kind_of = WAVE_FAST;
      default: kind_of = WAVE_PLAIN;
    endcase
  endfunction

  function automatic tcc_topsrc_type topsrc_of(input logic [3:0] m);
    case (m)
      4'h4, 4'h9, 4'hB, 4'hF: topsrc_of = TOP_CMPA;
      4'h8, 4'hA, 4'hC, 4'hE: topsrc_of = TOP_CAP;
      default: topsrc_of = TOP_FIXED;
    endcase
  endfunction

  function automatic logic [15:0] fixed_top(input logic [1:0] low);
    case (low)
      2'h1: fixed_top = TOP_8BIT;
      2'h2: fixed_top = TOP_9BIT;
      2'h3: fixed_top = TOP_10BIT;
      default: fixed_top = TOP_MAX;
    endcase
  endfunction

  // Next level of a compare output for one event
  function automatic logic wave_next(input logic cur, input logic [1:0] com, input tcc_kind_type k,
                                     input logic hit, input logic bottom, input logic down,
                                     input logic tog_ok);
    wave_next = cur;
    if (k == WAVE_PLAIN) begin
      if (hit) begin
        case (com)
          2'h1: wave_next = ~cur;
          2'h2: wave_next = 1'b0;
          2'h3: wave_next = 1'b1;
          default: wave_next = cur;
        endcase
      end
    end else if (com == 2'h1) begin
      if (hit && tog_ok) begin
        wave_next = ~cur;
      end
    end else if (com[1]) begin
      if (k == WAVE_FAST) begin
        if (bottom) begin
          wave_next = ~com[0];
        end else if (hit) begin
          wave_next = com[0];
        end
      end else if (hit) begin
        wave_next = com[0] ^ down;
      end
    end
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] irq_mask_ff;
  logic [7:0] irq_flags_ff;
  logic [7:0] control_a_ff;
  logic [7:0] control_b_ff;
  logic [15:0] counter_value_ff;
  logic [15:0] compare_a_ff;
  logic [15:0] compare_b_ff;
  logic [15:0] capture_ff;
  logic [7:0] temp_ff;
  logic dir_down_ff;
  logic block_ff;
  logic [PRESCALE_BITS-1:0] presc_ff;

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  logic wr_pend_ff;
  logic [7:0] wr_idx_ff;
  logic rd_go;
  logic [7:0] rd_idx;
  logic wr_go;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;

  assign rd_go = hsel && htrans[1] && hready && !hwrite;
  assign rd_idx = haddr[9:2];
  assign wr_go = wr_pend_ff;
  assign wr_byte = hwdata[7:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= RST_BYTE;
    end else if (hready) begin
      wr_pend_ff <= hsel && htrans[1] && hwrite;
      wr_idx_ff <= haddr[9:2];
    end
  end

  // Read data is formed in the address phase, so the slave never waits
  always_comb begin
    case (rd_idx)
      IDX_IRQ_MASK: rd_byte = irq_mask_ff & IRQ_BITS;
      IDX_IRQ_FLAGS: rd_byte = irq_flags_ff & IRQ_BITS;
      IDX_CONTROL_A: rd_byte = control_a_ff;
      IDX_CONTROL_B: rd_byte = control_b_ff & CONTROL_B_BITS;
      IDX_CONTROL_C: rd_byte = RST_BYTE;
      IDX_CNT_LOW: rd_byte = counter_value_ff[7:0];
      IDX_CAP_LOW: rd_byte = capture_ff[7:0];
      IDX_CMPA_LOW: rd_byte = compare_a_ff[7:0];
      IDX_CMPB_LOW: rd_byte = compare_b_ff[7:0];
      IDX_CNT_HIGH, IDX_CAP_HIGH, IDX_CMPA_HIGH, IDX_CMPB_HIGH: rd_byte = temp_ff;
      default: rd_byte = RST_BYTE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (rd_go) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  // Shared high-byte latch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      temp_ff <= RST_BYTE;
    end else if (wr_go && (wr_idx_ff == IDX_CNT_HIGH || wr_idx_ff == IDX_CAP_HIGH ||
                           wr_idx_ff == IDX_CMPA_HIGH || wr_idx_ff == IDX_CMPB_HIGH)) begin
      temp_ff <= wr_byte;
    end else if (rd_go) begin
      case (rd_idx)
        IDX_CNT_LOW: temp_ff <= counter_value_ff[15:8];
        IDX_CAP_LOW: temp_ff <= capture_ff[15:8];
        IDX_CMPA_LOW: temp_ff <= compare_a_ff[15:8];
        IDX_CMPB_LOW: temp_ff <= compare_b_ff[15:8];
        default: temp_ff <= temp_ff;
      endcase
    end
  end

  logic cnt_write;
  logic force_a_go;
  logic force_b_go;
  logic [3:0] waveform_mode;
  tcc_kind_type wave_kind;
  tcc_topsrc_type top_src;
  logic [2:0] clock_source_sel;

  assign cnt_write = wr_go && wr_idx_ff == IDX_CNT_LOW;
  assign waveform_mode = {control_b_ff[4:3], control_a_ff[1:0]};
  assign wave_kind = kind_of(waveform_mode);
  assign top_src = topsrc_of(waveform_mode);
  assign clock_source_sel = control_b_ff[2:0];
  assign force_a_go = wr_go && wr_idx_ff == IDX_CONTROL_C && wr_byte[BIT_FORCE_A] && wave_kind == WAVE_PLAIN;
  assign force_b_go = wr_go && wr_idx_ff == IDX_CONTROL_C && wr_byte[BIT_FORCE_B] && wave_kind == WAVE_PLAIN;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_ff <= RST_BYTE;
      control_a_ff <= RST_BYTE;
      control_b_ff <= RST_BYTE;
      compare_a_ff <= RST_WORD;
      compare_b_ff <= RST_WORD;
    end else if (wr_go) begin
      case (wr_idx_ff)
        IDX_IRQ_MASK: irq_mask_ff <= wr_byte & IRQ_BITS;
        IDX_CONTROL_A: control_a_ff <= wr_byte;
        IDX_CONTROL_B: control_b_ff <= wr_byte & CONTROL_B_BITS;
        IDX_CMPA_LOW: compare_a_ff <= {temp_ff, wr_byte};
        IDX_CMPB_LOW: compare_b_ff <= {temp_ff, wr_byte};
        default: irq_mask_ff <= irq_mask_ff;
      endcase
    end
  end

  // ************************************************************
  // Pin synchronisers and capture filter
  // ************************************************************
  logic [2:0] cap_sync_ff;
  logic [2:0] ext_sync_ff;
  logic cap_pin_ff;
  logic ext_pin_ff;
  logic ext_prev_ff;
  logic [FILTER_SAMPLES-1:0] cap_hist_ff;
  logic cap_filt_ff;
  logic cap_prev_ff;
  logic cap_level;
  logic cap_event;

  // A change counts once the second and third stages agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_sync_ff <= 3'h0;
      ext_sync_ff <= 3'h0;
      cap_pin_ff <= 1'b0;
      ext_pin_ff <= 1'b0;
    end else begin
      cap_sync_ff <= {cap_sync_ff[1:0], capture_pin};
      ext_sync_ff <= {ext_sync_ff[1:0], ext_count_pin};
      if (cap_sync_ff[1] == cap_sync_ff[2]) begin
        cap_pin_ff <= cap_sync_ff[2];
      end
      if (ext_sync_ff[1] == ext_sync_ff[2]) begin
        ext_pin_ff <= ext_sync_ff[2];
      end
    end
  end

  // Filter sees the same sample stream as the plain path, four stages later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_hist_ff <= '0;
      cap_filt_ff <= 1'b0;
    end else begin
      cap_hist_ff <= {cap_hist_ff[FILTER_SAMPLES-2:0], cap_pin_ff};
      if (&cap_hist_ff || ~|cap_hist_ff) begin
        cap_filt_ff <= cap_hist_ff[FILTER_SAMPLES-1];
      end
    end
  end

  always_comb begin
    if (acomp_capture_sel) begin
      cap_level = acomp_out;
    end else if (control_b_ff[BIT_NOISE_EN]) begin
      cap_level = cap_filt_ff;
    end else begin
      cap_level = cap_hist_ff[0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_prev_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else begin
      cap_prev_ff <= cap_level;
      ext_prev_ff <= ext_pin_ff;
    end
  end

  assign cap_event = (top_src != TOP_CAP) &&
                     (control_b_ff[BIT_EDGE_SEL] ? (cap_level && !cap_prev_ff) : (!cap_level && cap_prev_ff));

  // ************************************************************
  // Clock select
  // ************************************************************
  logic tick;

  // Prescaler runs free, so the first prescaled count can come early
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + 1'b1;
    end
  end

  always_comb begin
    case (clock_source_sel)
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = &presc_ff[2:0];
      CS_DIV64: tick = &presc_ff[5:0];
      CS_DIV256: tick = &presc_ff[7:0];
      CS_DIV1024: tick = &presc_ff[9:0];
      CS_EXT_FALL: tick = ext_prev_ff && !ext_pin_ff;
      CS_EXT_RISE: tick = !ext_prev_ff && ext_pin_ff;
      default: tick = 1'b0;
    endcase
  end

  // ************************************************************
  // Counter, compare and capture
  // ************************************************************
  logic [15:0] top_value;
  logic at_top;
  logic at_bottom_wrap;
  logic hit_a;
  logic hit_b;
  logic ovf_set;
  logic cap_top_set;

  always_comb begin
    case (top_src)
      TOP_CMPA: top_value = compare_a_ff;
      TOP_CAP: top_value = capture_ff;
      default: top_value = fixed_top(waveform_mode[1:0]);
    endcase
  end

  assign at_top = counter_value_ff == top_value;
  assign at_bottom_wrap = tick && at_top && wave_kind == WAVE_FAST;
  assign hit_a = tick && !block_ff && counter_value_ff == compare_a_ff;
  assign hit_b = tick && !block_ff && counter_value_ff == compare_b_ff;
  assign cap_top_set = tick && at_top && top_src == TOP_CAP;

  always_comb begin
    case (wave_kind)
      WAVE_PHASE: ovf_set = tick && dir_down_ff && counter_value_ff == RST_WORD;
      WAVE_FAST: ovf_set = tick && at_top;
      default: ovf_set = tick && counter_value_ff == TOP_MAX;
    endcase
  end

  // Block is held from a counter write to the next timer clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      block_ff <= 1'b0;
    end else if (cnt_write) begin
      block_ff <= 1'b1;
    end else if (tick) begin
      block_ff <= 1'b0;
    end
  end

  // Forced matches never touch the count, so clear-on-match mode is not cleared by them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      counter_value_ff <= RST_WORD;
      dir_down_ff <= 1'b0;
    end else if (cnt_write) begin
      counter_value_ff <= {temp_ff, wr_byte};
    end else if (wave_kind != WAVE_PHASE) begin
      dir_down_ff <= 1'b0;
      if (tick) begin
        counter_value_ff <= at_top ? RST_WORD : counter_value_ff + 16'h0001;
      end
    end else if (tick) begin
      if (!dir_down_ff && at_top) begin
        dir_down_ff <= 1'b1;
        counter_value_ff <= counter_value_ff - 16'h0001;
      end else if (dir_down_ff && counter_value_ff == RST_WORD) begin
        dir_down_ff <= 1'b0;
        counter_value_ff <= counter_value_ff + 16'h0001;
      end else begin
        counter_value_ff <= dir_down_ff ? counter_value_ff - 16'h0001 : counter_value_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capture_ff <= RST_WORD;
    end else if (wr_go && wr_idx_ff == IDX_CAP_LOW) begin
      capture_ff <= {temp_ff, wr_byte};
    end else if (cap_event) begin
      capture_ff <= counter_value_ff;
    end
  end

  // ************************************************************
  // Compare outputs
  // ************************************************************
  logic tog_ok_a;

  assign tog_ok_a = waveform_mode == 4'hE || waveform_mode == 4'hF || waveform_mode == 4'h9 || waveform_mode == 4'hB;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      compare_out_a <= 1'b0;
      compare_out_b <= 1'b0;
    end else begin
      compare_out_a <= wave_next(compare_out_a, control_a_ff[7:6], wave_kind, hit_a || force_a_go,
                                 at_bottom_wrap, dir_down_ff, tog_ok_a);
      compare_out_b <= wave_next(compare_out_b, control_a_ff[5:4], wave_kind, hit_b || force_b_go,
                                 at_bottom_wrap, dir_down_ff, 1'b0);
    end
  end

  // ************************************************************
  // Flags and interrupt requests
  // ************************************************************
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  always_comb begin
    flag_set = RST_BYTE;
    flag_set[BIT_CAP] = cap_event || cap_top_set;
    flag_set[BIT_CMPB] = hit_b;
    flag_set[BIT_CMPA] = hit_a;
    flag_set[BIT_OVF] = ovf_set;
    flag_clr = {2'h0, vector_ack[3], 2'h0, vector_ack[2:0]};
    if (wr_go && wr_idx_ff == IDX_IRQ_FLAGS) begin
      flag_clr = flag_clr | wr_byte;
    end
  end

  // Set beats clear when both land in one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_flags_ff <= RST_BYTE;
    end else begin
      irq_flags_ff <= ((irq_flags_ff & ~flag_clr) | flag_set) & IRQ_BITS;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_req <= 4'h0;
    end else begin
      irq_req <= {irq_flags_ff[BIT_CAP], irq_flags_ff[BIT_CMPB:BIT_OVF]} &
                 {irq_mask_ff[BIT_CAP], irq_mask_ff[BIT_CMPB:BIT_OVF]} & {4{irq_global_en}};
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  chk_force_read_zero: assert property (@(posedge clk) disable iff (!rstn)
    rd_go && rd_idx == IDX_CONTROL_C |=> hrdata == 32'h00000000) else $error("force bits read non-zero");
  chk_filter_stable: assert property (@(posedge clk) disable iff (!rstn)
    $changed(cap_filt_ff) |-> $past(&cap_hist_ff || ~|cap_hist_ff)) else $error("filter moved early");
  chk_capture_copy: assert property (@(posedge clk) disable iff (!rstn)
    cap_event && !wr_go |=> capture_ff == $past(counter_value_ff) && irq_flags_ff[BIT_CAP])
    else $error("capture not taken");
  chk_capture_off: assert property (@(posedge clk) disable iff (!rstn)
    top_src == TOP_CAP |-> !cap_event) else $error("capture while ceiling");
  chk_clock_stop: assert property (@(posedge clk) disable iff (!rstn)
    clock_source_sel == CS_STOP |-> !tick) else $error("count while stopped");
  chk_div_eight: assert property (@(posedge clk) disable iff (!rstn)
    clock_source_sel == CS_DIV8 && tick |-> ##1 (!tick || clock_source_sel != CS_DIV8) [*7])
    else $error("div8 spacing wrong");
  chk_force_clear: assert property (@(posedge clk) disable iff (!rstn)
    force_a_go && control_a_ff[7:6] == 2'h2 |=> !compare_out_a) else $error("forced clear failed");
  chk_write_block: assert property (@(posedge clk) disable iff (!rstn)
    cnt_write |=> block_ff && !hit_a && !hit_b) else $error("match after counter write");
  chk_flag_sets: assert property (@(posedge clk) disable iff (!rstn)
    hit_a |=> irq_flags_ff[BIT_CMPA]) else $error("compare flag lost");
  chk_irq_request: assert property (@(posedge clk) disable iff (!rstn)
    irq_flags_ff[BIT_OVF] && irq_mask_ff[BIT_OVF] && irq_global_en |=> irq_req[0])
    else $error("overflow request missing");
  chk_mask_zero: assert property (@(posedge clk) disable iff (!rstn)
    (irq_mask_ff & ~IRQ_BITS) == RST_BYTE) else $error("reserved mask bit set");

endmodule

// [hw/tcc_pkg.sv]
// Package for the 16-bit timer/counter register block: register indices,
// field positions, reset values, clock-select codes, counter tops and waveform kind types.
// Assumes a byte-wide register map where a register index is a word address.
package tcc_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h36;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h6F;
  localparam logic [7:0] IDX_CONTROL_A = 8'h80;
  localparam logic [7:0] IDX_CONTROL_B = 8'h81;
  localparam logic [7:0] IDX_CONTROL_C = 8'h82;
  localparam logic [7:0] IDX_CNT_LOW = 8'h84;
  localparam logic [7:0] IDX_CNT_HIGH = 8'h85;
  localparam logic [7:0] IDX_CAP_LOW = 8'h86;
  localparam logic [7:0] IDX_CAP_HIGH = 8'h87;
  localparam logic [7:0] IDX_CMPA_LOW = 8'h88;
  localparam logic [7:0] IDX_CMPA_HIGH = 8'h89;
  localparam logic [7:0] IDX_CMPB_LOW = 8'h8A;
  localparam logic [7:0] IDX_CMPB_HIGH = 8'h8B;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_NOISE_EN = 7;
  localparam int BIT_EDGE_SEL = 6;
  localparam int BIT_FORCE_A = 7;
  localparam int BIT_FORCE_B = 6;
  localparam int BIT_CAP = 5;
  localparam int BIT_CMPB = 2;
  localparam int BIT_CMPA = 1;
  localparam int BIT_OVF = 0;
  localparam logic [7:0] IRQ_BITS = 8'h27;
  localparam logic [7:0] CONTROL_B_BITS = 8'hDF;

  // ************************************************************
  // Reset values and timing counts
  // ************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int FILTER_SAMPLES = 4;
  localparam int PRESCALE_BITS = 10;

  // ************************************************************
  // Clock-select codes and counter tops
  // ************************************************************
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {WAVE_PLAIN, WAVE_FAST, WAVE_PHASE} tcc_kind_type;
  typedef enum logic [1:0] {TOP_FIXED, TOP_CMPA, TOP_CAP} tcc_topsrc_type;

endpackage

// [sim/timer16_capture_compare_regs_bench.sv]
// Bench for the timer block: bus tasks and one task per scenario.
// Assumes hready is fed back from hreadyout and byte data in bit 7:0.
`timescale 1ns/1ps
module timer16_capture_compare_regs_bench;
  import tcc_pkg::*;
  logic clk, rstn, hwrite, capture_pin, ext_count_pin, irq_global_en, acomp_out, acomp_capture_sel;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata;
  logic [3:0] vector_ack;
  wire hreadyout, hresp, compare_out_a, compare_out_b;
  wire [31:0] hrdata;
  wire [3:0] irq_req;
  logic [7:0] d;
  int n_fail, cmp_count;
  tcc_timer16 dut_u (.clk(clk), .rstn(rstn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .capture_pin(capture_pin), .ext_count_pin(ext_count_pin),
    .acomp_out(acomp_out), .acomp_capture_sel(acomp_capture_sel), .irq_global_en(irq_global_en),
    .vector_ack(vector_ack), .irq_req(irq_req), .compare_out_a(compare_out_a),
    .compare_out_b(compare_out_b));
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic xfer(input logic [7:0] i, input logic w, input logic [7:0] v);
    @(posedge clk);
    haddr <= {22'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata[7:0];
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] i, input logic [7:0] m, input logic [7:0] exp);
    xfer(i, 1'b0, 8'h00);
    chk(d & m, exp);
  endtask
  task automatic test_done();
    $display("n_fail=%0d cmp_count=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rc(IDX_CONTROL_B, 8'hFF, 8'h00);
    xfer(IDX_IRQ_MASK, 1'b1, 8'hFF);
    rc(IDX_IRQ_MASK, 8'hFF, 8'h27);
    xfer(IDX_CONTROL_C, 1'b1, 8'hC0);
    rc(IDX_CONTROL_C, 8'hFF, 8'h00);
    xfer(IDX_CMPB_HIGH, 1'b1, 8'h12);
    xfer(IDX_CMPB_LOW, 1'b1, 8'h34);
    rc(IDX_CMPB_LOW, 8'hFF, 8'h34);
    rc(IDX_CMPB_HIGH, 8'hFF, 8'h12);
    xfer(IDX_IRQ_MASK, 1'b1, 8'h00);
  endtask
  task automatic t_match();
    xfer(IDX_CONTROL_A, 1'b1, 8'hC0);
    xfer(IDX_CMPA_HIGH, 1'b1, 8'h00);
    xfer(IDX_CMPA_LOW, 1'b1, 8'h05);
    xfer(IDX_CNT_HIGH, 1'b1, 8'h00);
    xfer(IDX_CNT_LOW, 1'b1, 8'h00);
    xfer(IDX_CONTROL_B, 1'b1, {5'h0, CS_DIV1});
    repeat (20) @(posedge clk);
    xfer(IDX_CONTROL_B, 1'b1, 8'h00);
    rc(IDX_IRQ_FLAGS, 8'h02, 8'h02);
    chk({7'h0, compare_out_a}, 8'h01);
    xfer(IDX_IRQ_MASK, 1'b1, 8'h02);
    irq_global_en <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h0, irq_req[1]}, 8'h01);
    xfer(IDX_IRQ_FLAGS, 1'b1, 8'h02);
    rc(IDX_IRQ_FLAGS, 8'h02, 8'h00);
    xfer(IDX_CONTROL_A, 1'b1, 8'hB0);
    xfer(IDX_CONTROL_C, 1'b1, 8'hC0);
    @(posedge clk);
    chk({6'h00, compare_out_a, compare_out_b}, 8'h01);
    rc(IDX_IRQ_FLAGS, 8'h06, 8'h00);
  endtask
  task automatic t_capture();
    xfer(IDX_CONTROL_B, 1'b1, 8'h40);
    capture_pin <= 1'b1;
    repeat (10) @(posedge clk);
    rc(IDX_IRQ_FLAGS, 8'h20, 8'h20);
    xfer(IDX_IRQ_FLAGS, 1'b1, 8'h20);
    capture_pin <= 1'b0;
    repeat (10) @(posedge clk);
    rc(IDX_IRQ_FLAGS, 8'h20, 8'h00);
    xfer(IDX_CONTROL_B, 1'b1, 8'h80);
    capture_pin <= 1'b1;
    repeat (12) @(posedge clk);
    rc(IDX_IRQ_FLAGS, 8'h20, 8'h00);
    capture_pin <= 1'b0;
    repeat (12) @(posedge clk);
    rc(IDX_IRQ_FLAGS, 8'h20, 8'h20);
    xfer(IDX_IRQ_FLAGS, 1'b1, 8'h20);
    acomp_capture_sel <= 1'b1;
    acomp_out <= 1'b1;
    repeat (3) @(posedge clk);
    acomp_out <= 1'b0;
    repeat (3) @(posedge clk);
    acomp_capture_sel <= 1'b0;
    rc(IDX_IRQ_FLAGS, 8'h20, 8'h20);
  endtask
  task automatic t_presc();
    xfer(IDX_CNT_HIGH, 1'b1, 8'h00);
    xfer(IDX_CNT_LOW, 1'b1, 8'h00);
    xfer(IDX_CONTROL_B, 1'b1, {5'h0, CS_DIV8});
    // Select stands 64 clocks in all, so exactly eight prescaler taps fall inside
    repeat (61) @(posedge clk);
    xfer(IDX_CONTROL_B, 1'b1, 8'h00);
    rc(IDX_CNT_LOW, 8'hFF, 8'h08);
  endtask
  task automatic t_ext();
    xfer(IDX_CNT_HIGH, 1'b1, 8'h00);
    xfer(IDX_CNT_LOW, 1'b1, 8'h00);
    xfer(IDX_CONTROL_B, 1'b1, {5'h0, CS_EXT_RISE});
    repeat (3) begin
      repeat (4) @(posedge clk);
      ext_count_pin <= 1'b1;
      repeat (4) @(posedge clk);
      ext_count_pin <= 1'b0;
    end
    repeat (6) @(posedge clk);
    rc(IDX_CNT_LOW, 8'hFF, 8'h03);
  endtask
  // ****************************************
  // Clock, reset, sequence and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    {hwrite, capture_pin, ext_count_pin, irq_global_en, acomp_out, acomp_capture_sel} = 6'h00;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    vector_ack = 4'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_match();
    t_capture();
    t_presc();
    t_ext();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule
